// ### core/cibs_pkg.sv
// constants shared by the interrupt and bus status unit
`default_nettype none
package cibs_pkg;
   // restart vectors
   localparam logic [7:0] CIBS_VEC_TRAP = 8'h24;
   localparam logic [7:0] CIBS_VEC_R55 = 8'h2c;
   localparam logic [7:0] CIBS_VEC_R65 = 8'h34;
   localparam logic [7:0] CIBS_VEC_R75 = 8'h3c;
   localparam logic [7:0] CIBS_VEC_NONE = 8'h00;
   localparam logic [2:0] CIBS_RST_SHIFT = 3'h3; // restart n jumps to n times 8
   localparam logic [15:0] CIBS_SP_STEP = 16'h0002;
   // mask read byte layout
   localparam int CIBS_RD_SID = 7;
   localparam int CIBS_RD_P75 = 6;
   localparam int CIBS_RD_P65 = 5;
   localparam int CIBS_RD_P55 = 4;
   localparam int CIBS_RD_IE = 3;
   localparam int CIBS_RD_M75 = 2;
   localparam int CIBS_RD_M65 = 1;
   localparam int CIBS_RD_M55 = 0;
   // bus status codes {s1,s0}
   localparam logic [1:0] CIBS_ST_HALT = 2'h0;
   localparam logic [1:0] CIBS_ST_WRITE = 2'h1;
   localparam logic [1:0] CIBS_ST_READ = 2'h2;
   localparam logic [1:0] CIBS_ST_FETCH = 2'h3;
   localparam int CIBS_NRST = 3;
   localparam logic [2:0] CIBS_MASK_RST = 3'h7; // all restarts masked
   // accepted source codes
   typedef enum logic [2:0] {
      CIBS_SRC_NONE, CIBS_SRC_TRAP, CIBS_SRC_R75, CIBS_SRC_R65, CIBS_SRC_R55, CIBS_SRC_GEN
   } cibs_src_t;
   // bus cycle requested by the sequencer
   typedef enum logic [2:0] {
      CIBS_CYC_HALT, CIBS_CYC_FETCH, CIBS_CYC_READ, CIBS_CYC_WRITE, CIBS_CYC_DADIDLE, CIBS_CYC_ACK
   } cibs_cyc_t;
endpackage
`default_nettype wire

// ### core/cibs_sync.sv
// two-flop synchroniser bank for asynchronous inputs
`default_nettype none
module cibs_sync #(
   parameter int W = 1
) (
   input wire logic clk, // processor clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [W-1:0] d, // raw inputs
   output logic [W-1:0] q // synchronised inputs
);
   logic [W-1:0] meta_q;
   // first stage only feeds second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### core/cibs_top.sv
// interrupt priority, masks, serial lines and bus status of the processor
`default_nettype none
// How it works
// (R1) each restart input has own mask bit
// (R2) enabled unmasked request makes internal restart
// (R3) trap restarts regardless of enable, masks
// (R4) vectors 24, 2c, 34, 3c hex
// (R5) 5.5 and 6.5 level, sampled like general
// (R6) 7.5 rising edge sets pending latch
// (R7) 7.5 latch holds until serviced, cleared, reset
// (R8) 7.5 latches even masked and disabled
// (R9) masks change only on mask set, reset
// (R10) priority trap, 7.5, 6.5, 5.5, general
// (R11) arbitration ignores running service routine
// (R12) trap needs new rise, level still high
// (R13) trap source holds high until acknowledged
// (R14) read samples serial in; set loads out
// (R15) status codes halt, write, read, fetch
// (R16) double add idle cycles show read status
// (R17) status ahead of transfer, strobed by latch enable
// (R18) hold, ready, interrupts synchronised first
// (R19) restart n pushes, sp minus two, jumps n*8
// (R20) ready low stretches the cycle
// (R21) global enable cleared at reset and accept
// (R22) mask read returns masks, pending, serial in
// (R23) acknowledge strobe replaces read after general
// (R24) serial out high after reset
// (R25) 7.5 cleared on ack; levels re-evaluated live
// (R26) mask set carries masks, qualifiers, clear, data

module cibs_top
   import cibs_pkg::*;
(
   input wire logic clk, // processor clock, 40 MHz
   input wire logic rst_n, // synchronous reset, active low
   input wire logic general_irq_input, // general request, high level
   input wire logic rst55_in, // restart 5.5, high level
   input wire logic rst65_in, // restart 6.5, high level
   input wire logic rst75_in, // restart 7.5, rising edge
   input wire logic trap_in, // non-maskable restart
   input wire logic hold_in, // bus hold request
   input wire logic ready_in, // memory ready
   input wire logic serial_in_line, // serial input
   input wire logic sample_point, // last cycle of instruction
   input wire logic enable_irq_instruction, // sets global enable
   input wire logic disable_irq_instruction, // clears global enable
   input wire logic mask_read_instruction, // latch mask read byte
   input wire logic mask_set_instruction, // mask set executes
   input wire logic [2:0] set_mask_val, // new masks 7.5,6.5,5.5
   input wire logic set_mask_upd, // masks take set_mask_val
   input wire logic set_clr75, // clear 7.5 pending
   input wire logic set_sod_upd, // serial out takes set_sod_val
   input wire logic set_sod_val, // serial out data
   input wire logic cyc_start, // start of a machine cycle
   input wire cibs_cyc_t cyc_kind, // kind of machine cycle
   input wire logic rst_instr, // restart instruction executes
   input wire logic [2:0] rst_index, // restart instruction index
   input wire logic [15:0] pc_in, // return address
   input wire logic [15:0] sp_in, // current stack pointer

   output logic irq_take, // restart accepted this cycle
   output cibs_src_t irq_src, // source of accepted request
   output logic [7:0] irq_vector, // restart vector address
   output logic global_irq_enable, // global enable state
   output logic [7:0] mask_read_data, // byte for accumulator
   output logic serial_out_line, // serial output
   output logic [1:0] bus_status, // {s1,s0}
   output logic ale, // address latch enable
   output logic rd_strobe_n, // read strobe, active low
   output logic irq_acknowledge_strobe_n, // acknowledge strobe, active low
   output logic wr_strobe_n, // write strobe, active low
   output logic cyc_wait, // cycle stretched by ready
   output logic hold_sync, // synchronised hold
   output logic [15:0] push_addr, // return address to push
   output logic [15:0] sp_next, // stack pointer after push
   output logic [15:0] jump_addr, // restart target
   output logic push_valid // restart push and jump data valid
);
   logic [6:0] sync_q;
   logic gen_s, r55_s, r65_s, r75_s, trap_s, ready_s;
   logic r75_d1_q, trap_d1_q, trap_arm_q;
   logic [2:0] mask_q; // [2]=7.5 [1]=6.5 [0]=5.5
   logic pend75_q, ie_q, sod_q;

   logic trap_req, r75_req, r65_req, r55_req, gen_req;
   cibs_src_t win;
   logic ack_pend_q;

   logic [1:0] stat_q;
   logic ale_q, rd_q, ack_q, wr_q;
   logic [7:0] vec_q, rim_q;
   cibs_src_t src_q;
   logic take_q;

   logic [15:0] push_q, spn_q, jmp_q;
   logic pv_q;
   logic active_q, is_rd_q, is_wr_q, is_ack_q;

   // ----------------------------------------
   // input synchronisation
   // ----------------------------------------
   // raw request, hold and ready pins pass two flops before any use; serial input is used unsynchronised
   cibs_sync #(.W(7)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({general_irq_input, rst55_in, rst65_in, rst75_in, trap_in, hold_in, ready_in}),
      .q(sync_q)
   ); // (R18)

   assign {gen_s, r55_s, r65_s, r75_s, trap_s, hold_sync, ready_s} = sync_q;

   // ----------------------------------------
   // edge capture and pending state
   // ----------------------------------------
   // delayed copies for edge detection, taken off the synchronised side
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r75_d1_q <= 1'b0;
         trap_d1_q <= 1'b0;
      end else begin
         r75_d1_q <= r75_s;
         trap_d1_q <= trap_s;
      end
   end

   // 7.5 latch: edge wins over a same-cycle clear so no request is lost
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend75_q <= 1'b0; // (R7)
      end else if (r75_s && !r75_d1_q) begin
         pend75_q <= 1'b1; // (R6) (R8)
      end else if ((mask_set_instruction && set_clr75) || (take_q && src_q == CIBS_SRC_R75)) begin
         pend75_q <= 1'b0; // (R7) (R25)
      end
   end

   // trap armed on a rise, disarmed once acknowledged; glitch-proof by needing level too
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trap_arm_q <= 1'b0;
      end else if (trap_s && !trap_d1_q) begin
         trap_arm_q <= 1'b1; // (R12)
      end else if (!trap_s || (take_q && src_q == CIBS_SRC_TRAP)) begin
         trap_arm_q <= 1'b0; // (R12) (R13)
      end
   end

   // ----------------------------------------
   // masks, enable and serial output
   // ----------------------------------------
   // masks move only on the mask set path
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mask_q <= CIBS_MASK_RST; // (R9)
      end else if (mask_set_instruction && set_mask_upd) begin
         mask_q <= set_mask_val; // (R1) (R9) (R26)
      end
   end

   // acceptance clears enable, and beats an enable in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ie_q <= 1'b0; // (R21)
      end else if (irq_take || disable_irq_instruction) begin
         ie_q <= 1'b0; // (R21)
      end else if (enable_irq_instruction) begin
         ie_q <= 1'b1;
      end
   end

   // serial output latch, idles high
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sod_q <= 1'b1; // (R24)
      end else if (mask_set_instruction && set_sod_upd) begin
         sod_q <= set_sod_val; // (R14) (R26)
      end
   end

   // mask read byte, sampled when the instruction runs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rim_q <= 8'h00;
      end else if (mask_read_instruction) begin
         rim_q[CIBS_RD_SID] <= serial_in_line; // (R14) (R22)
         rim_q[CIBS_RD_P75] <= pend75_q; // (R22)
         rim_q[CIBS_RD_P65] <= r65_s;
         rim_q[CIBS_RD_P55] <= r55_s;
         rim_q[CIBS_RD_IE] <= ie_q;
         rim_q[CIBS_RD_M75] <= mask_q[2];
         rim_q[CIBS_RD_M65] <= mask_q[1];
         rim_q[CIBS_RD_M55] <= mask_q[0];
      end
   end

   // ----------------------------------------
   // priority arbitration
   // ----------------------------------------
   // levels come from the synchronised inputs each sample point; no in-service memory kept
   assign trap_req = trap_arm_q && trap_s; // (R3) (R12)
   assign r75_req = ie_q && !mask_q[2] && pend75_q; // (R2)
   assign r65_req = ie_q && !mask_q[1] && r65_s; // (R2) (R5) (R25)
   assign r55_req = ie_q && !mask_q[0] && r55_s; // (R2) (R5) (R25)
   assign gen_req = ie_q && gen_s;

   always_comb begin
      win = CIBS_SRC_NONE;
      if (trap_req) begin
         win = CIBS_SRC_TRAP; // (R10)
      end else if (r75_req) begin
         win = CIBS_SRC_R75;
      end else if (r65_req) begin
         win = CIBS_SRC_R65;
      end else if (r55_req) begin
         win = CIBS_SRC_R55;
      end else if (gen_req) begin
         win = CIBS_SRC_GEN; // (R11)
      end
   end

   assign irq_take = sample_point && (win != CIBS_SRC_NONE); // (R5)

   // registered result of the acceptance
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         take_q <= 1'b0;
         src_q <= CIBS_SRC_NONE;
         vec_q <= CIBS_VEC_NONE;
      end else begin
         take_q <= irq_take;
         if (irq_take) begin
            src_q <= win;
            case (win)
               CIBS_SRC_TRAP: vec_q <= CIBS_VEC_TRAP; // (R4)
               CIBS_SRC_R75: vec_q <= CIBS_VEC_R75; // (R4)
               CIBS_SRC_R65: vec_q <= CIBS_VEC_R65; // (R4)
               CIBS_SRC_R55: vec_q <= CIBS_VEC_R55; // (R4)
               default: vec_q <= CIBS_VEC_NONE; // general: vector comes from bus
            endcase
         end
      end
   end

   // general acceptance arms the acknowledge strobe for every read or fetch cycle until a halt cycle starts
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_pend_q <= 1'b0;
      end else if (irq_take && win == CIBS_SRC_GEN) begin
         ack_pend_q <= 1'b1; // (R23)
      end else if (cyc_start && cyc_kind == CIBS_CYC_HALT) begin
         ack_pend_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // restart push and jump
   // ----------------------------------------
   // restart return data taken once per instruction
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         push_q <= 16'h0000;
         spn_q <= 16'h0000;
         jmp_q <= 16'h0000;
         pv_q <= 1'b0;
      end else begin
         pv_q <= rst_instr;
         if (rst_instr) begin
            push_q <= pc_in; // (R19)
            spn_q <= sp_in - CIBS_SP_STEP; // (R19)
            jmp_q <= {13'h0000, rst_index} << CIBS_RST_SHIFT; // (R19)
         end
      end
   end

   // ----------------------------------------
   // bus status and strobes
   // ----------------------------------------
   // status and latch enable in the first clock; strobes until ready
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stat_q <= CIBS_ST_HALT;
         ale_q <= 1'b0;
         active_q <= 1'b0;
         is_rd_q <= 1'b0;
         is_wr_q <= 1'b0;
         is_ack_q <= 1'b0;
      end else if (cyc_start) begin
         ale_q <= (cyc_kind != CIBS_CYC_HALT) && (cyc_kind != CIBS_CYC_DADIDLE); // (R17)
         active_q <= (cyc_kind != CIBS_CYC_HALT) && (cyc_kind != CIBS_CYC_DADIDLE);
         is_rd_q <= (cyc_kind == CIBS_CYC_READ || cyc_kind == CIBS_CYC_FETCH) && !ack_pend_q;
         is_ack_q <= (cyc_kind == CIBS_CYC_ACK) || ((cyc_kind == CIBS_CYC_READ ||
                     cyc_kind == CIBS_CYC_FETCH) && ack_pend_q); // (R23)
         is_wr_q <= cyc_kind == CIBS_CYC_WRITE;
         case (cyc_kind)
            CIBS_CYC_HALT: stat_q <= CIBS_ST_HALT; // (R15)
            CIBS_CYC_WRITE: stat_q <= CIBS_ST_WRITE; // (R15)
            CIBS_CYC_READ: stat_q <= CIBS_ST_READ; // (R15)
            CIBS_CYC_DADIDLE: stat_q <= CIBS_ST_READ; // (R16)
            CIBS_CYC_FETCH: stat_q <= CIBS_ST_FETCH; // (R15)
            CIBS_CYC_ACK: stat_q <= CIBS_ST_FETCH;
            default: stat_q <= CIBS_ST_HALT;
         endcase
      end else begin
         ale_q <= 1'b0;
         if (active_q && !ale_q && ready_s) begin
            active_q <= 1'b0; // (R20)
         end
      end
   end

   // strobes run after the latch enable and hold while ready is low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_q <= 1'b1;
         wr_q <= 1'b1;
         ack_q <= 1'b1;
      end else begin
         rd_q <= !(ale_q && is_rd_q) && !(rd_q == 1'b0 && !ready_s && active_q); // (R20)
         wr_q <= !(ale_q && is_wr_q) && !(wr_q == 1'b0 && !ready_s && active_q);
         ack_q <= !(ale_q && is_ack_q) && !(ack_q == 1'b0 && !ready_s && active_q);
      end
   end

   // outputs come straight from their registers, except cyc_wait, which is decoded from them, and irq_take, which is combinational
   assign cyc_wait = active_q && !ale_q && !ready_s; // (R20)
   assign irq_src = src_q;
   assign irq_vector = vec_q;
   assign global_irq_enable = ie_q;
   assign mask_read_data = rim_q;
   assign serial_out_line = sod_q;
   assign bus_status = stat_q;
   assign ale = ale_q;
   assign rd_strobe_n = rd_q;
   assign wr_strobe_n = wr_q;
   assign irq_acknowledge_strobe_n = ack_q;
   assign push_addr = push_q;
   assign sp_next = spn_q;
   assign jump_addr = jmp_q;
   assign push_valid = pv_q;
endmodule
`default_nettype wire

// ### test/cibs_peri.sv
// peripheral side model: trap source, slow memory, status latch
`default_nettype none
module cibs_peri
   import cibs_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic trap_go, // raise trap
   input wire logic trap_keep, // hold trap up
   input wire logic [3:0] wait_cyc, // wait cycles
   input wire logic irq_take, // accept seen
   input wire logic ale, // status strobe
   input wire logic [1:0] bus_status, // status
   input wire logic rd_strobe_n, // read strobe
   output logic trap_in, // trap line
   output logic ready_in, // ready line
   output logic [1:0] st_seen // latched status
);
   timeunit 1ns;
   timeprecision 100ps;
   logic keep_q;
   logic [3:0] wcnt_q;
   // ----
   // behaviour
   // ----
   // trap held until the source lets go, or until taken while trap_keep is low
   always @(posedge clk) begin
      keep_q <= trap_keep;
      if (!rst_n || (keep_q && !trap_keep) || (!trap_keep && irq_take)) begin
         trap_in <= 1'b0;
      end else if (trap_go) begin
         trap_in <= 1'b1;
      end
   end
   // slow memory counts strobe cycles; status latched by ale
   always @(posedge clk) begin
      wcnt_q <= rd_strobe_n ? 4'h0 : wcnt_q + 4'h1;
      if (ale) begin
         st_seen <= bus_status;
      end
   end
   assign ready_in = !(wcnt_q < wait_cyc);
endmodule
`default_nettype wire

// ### test/cibs_top_sva.sv
// port assertions for the interrupt and bus status unit
`default_nettype none
module cibs_top_sva
   import cibs_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic cyc_start, // cycle start
   input wire cibs_cyc_t cyc_kind, // cycle kind
   input wire logic [1:0] bus_status, // status code
   input wire logic ale, // status strobe
   input wire logic rd_strobe_n, // read strobe
   input wire logic irq_acknowledge_strobe_n, // ack strobe
   input wire logic cyc_wait, // stretched
   input wire logic irq_take, // accepted
   input wire cibs_src_t irq_src, // source
   input wire logic [7:0] irq_vector, // vector
   input wire logic global_irq_enable, // enable
   input wire logic rst_instr, // restart
   input wire logic [2:0] rst_index, // restart index
   input wire logic push_valid, // push valid
   input wire logic [15:0] jump_addr, // target
   input wire logic serial_out_line // serial out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----
   // checks
   // ----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_read_status: assert property (
      cyc_start && cyc_kind == CIBS_CYC_READ |=> bus_status == CIBS_ST_READ && ale)
      else $error("read status wrong");
   a_dad_idle: assert property (
      cyc_start && cyc_kind == CIBS_CYC_DADIDLE |=> bus_status == CIBS_ST_READ && !ale)
      else $error("idle add status wrong");
   a_ale_single: assert property (ale |=> !ale)
      else $error("strobe too long");
   a_strobe_follows: assert property (
      ale && bus_status == CIBS_ST_READ |=> !(rd_strobe_n && irq_acknowledge_strobe_n))
      else $error("no strobe after ale");
   a_ready_stretch: assert property (!rd_strobe_n && cyc_wait |=> !rd_strobe_n)
      else $error("strobe ended early");
   a_take_clears_ie: assert property (irq_take |=> !global_irq_enable)
      else $error("enable kept after take");
   a_trap_vector: assert property (
      irq_take ##1 irq_src == CIBS_SRC_TRAP |-> irq_vector == CIBS_VEC_TRAP)
      else $error("trap vector wrong");
   a_restart_jump: assert property (
      rst_instr |=> push_valid && jump_addr == {10'h000, $past(rst_index), 3'h0})
      else $error("restart target wrong");
   a_reset_state: assert property (disable iff (1'b0)
      $rose(rst_n) |-> serial_out_line && !global_irq_enable && !ale && bus_status == 2'h0)
      else $error("reset state wrong");
   // main scenarios reached
   cover property (irq_take ##1 irq_src == CIBS_SRC_TRAP);
   cover property (!rd_strobe_n && cyc_wait);
   cover property (!irq_acknowledge_strobe_n);
endmodule
bind cibs_top cibs_top_sva i_sva (.clk, .rst_n, .cyc_start, .cyc_kind, .bus_status, .ale,
   .rd_strobe_n, .irq_acknowledge_strobe_n, .cyc_wait, .irq_take, .irq_src, .irq_vector,
   .global_irq_enable, .rst_instr, .rst_index, .push_valid, .jump_addr, .serial_out_line);
`default_nettype wire

// ### test/test_cibs_top.sv
// self-checking bench for the interrupt and bus status unit
`default_nettype none
module test_cibs_top
   import cibs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic general_irq_input = 1'b0, rst55_in = 1'b0, rst65_in = 1'b0, rst75_in = 1'b0;
   logic hold_in = 1'b0, serial_in_line = 1'b0, sample_point = 1'b0, rst_instr = 1'b0;
   logic enable_irq_instruction = 1'b0, disable_irq_instruction = 1'b0, cyc_start = 1'b0;
   logic mask_read_instruction = 1'b0, mask_set_instruction = 1'b0, set_mask_upd = 1'b0;
   logic set_clr75 = 1'b0, set_sod_upd = 1'b0, set_sod_val = 1'b0, trap_go = 1'b0;
   logic trap_keep = 1'b0;
   logic [2:0] set_mask_val = 3'h0, rst_index = 3'h0;
   logic [3:0] wait_cyc = 4'h0;
   logic [15:0] pc_in = 16'h1234, sp_in = 16'h2000;
   cibs_cyc_t cyc_kind = CIBS_CYC_HALT;
   logic trap_in, ready_in, irq_take, global_irq_enable, serial_out_line, ale, cyc_wait;
   logic rd_strobe_n, irq_acknowledge_strobe_n, wr_strobe_n, hold_sync, push_valid;
   cibs_src_t irq_src;
   logic [7:0] irq_vector, mask_read_data, d;
   logic [1:0] bus_status, st_seen;
   logic [2:0] st_now;
   logic [15:0] push_addr, sp_next, jump_addr, r;
   logic saw_rd, saw_ack;
   int n_mismatch = 0, comparisons = 0, cycles = 0, lowc = 0;
   cibs_top i_dut (.clk, .rst_n, .general_irq_input, .rst55_in, .rst65_in, .rst75_in, .trap_in,
      .hold_in, .ready_in, .serial_in_line, .sample_point, .enable_irq_instruction,
      .disable_irq_instruction, .mask_read_instruction, .mask_set_instruction, .set_mask_val,
      .set_mask_upd, .set_clr75, .set_sod_upd, .set_sod_val, .cyc_start, .cyc_kind, .rst_instr,
      .rst_index, .pc_in, .sp_in, .irq_take, .irq_src, .irq_vector, .global_irq_enable,
      .mask_read_data, .serial_out_line, .bus_status, .ale, .rd_strobe_n,
      .irq_acknowledge_strobe_n, .wr_strobe_n, .cyc_wait, .hold_sync, .push_addr, .sp_next,
      .jump_addr, .push_valid);
   cibs_peri i_peri (.clk, .rst_n, .trap_go, .trap_keep, .wait_cyc, .irq_take, .ale,
      .bus_status, .rd_strobe_n, .trap_in, .ready_in, .st_seen);
   // 40 MHz clock; hang guard well above the few hundred cycles needed
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_mismatch++;
         test_done();
      end
   end
   // ----
   // helpers
   // ----
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic ei();
      enable_irq_instruction = 1'b1;
      tick();
      enable_irq_instruction = 1'b0;
   endtask
   task automatic mset(input logic [2:0] m, input logic c75);
      mask_set_instruction = 1'b1;
      set_mask_upd = 1'b1;
      set_mask_val = m;
      set_clr75 = c75;
      tick();
      mask_set_instruction = 1'b0;
      set_mask_upd = 1'b0;
      set_clr75 = 1'b0;
   endtask
   task automatic mrd(output logic [7:0] v);
      mask_read_instruction = 1'b1;
      tick();
      mask_read_instruction = 1'b0;
      v = mask_read_data;
   endtask
   // returns {take flag, vector}; trailing tick keeps pulses apart
   task automatic samp(output logic [15:0] v);
      logic t;
      sample_point = 1'b1;
      #1;
      t = irq_take;
      tick();
      sample_point = 1'b0;
      v = {7'h00, t, irq_vector};
      tick();
   endtask
   task automatic pulse75();
      rst75_in = 1'b1;
      tick(2);
      rst75_in = 1'b0;
      tick(3);
   endtask
   // bus cycle: status after start, then strobe low time
   task automatic cyc(input cibs_cyc_t k);
      cyc_kind = k;
      cyc_start = 1'b1;
      tick();
      cyc_start = 1'b0;
      st_now = {bus_status, ale};
      saw_rd = 1'b0;
      saw_ack = 1'b0;
      lowc = 0;
      tick();
      while (lowc < 30 && !(rd_strobe_n && irq_acknowledge_strobe_n && wr_strobe_n)) begin
         saw_rd |= !rd_strobe_n;
         saw_ack |= !irq_acknowledge_strobe_n;
         lowc++;
         tick();
      end
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset();
      mrd(d);
      chk16({8'h00, d}, 16'h0007);
      chk1(serial_out_line, 1'b1);
      hold_in = 1'b1;
      tick(3);
      chk1(hold_sync, 1'b1);
      hold_in = 1'b0;
      $display("reset test done");
   endtask
   task automatic t_bus();
      cibs_cyc_t ks[4] = '{CIBS_CYC_FETCH, CIBS_CYC_READ, CIBS_CYC_WRITE, CIBS_CYC_DADIDLE};
      logic [2:0] ex[4] = '{3'h7, 3'h5, 3'h3, 3'h4};
      for (int i = 0; i < 4; i++) begin
         cyc(ks[i]);
         chk16({12'h000, lowc[0], st_now}, {12'h000, i < 3, ex[i]});
      end
      chk16({14'h0000, st_seen}, {14'h0000, CIBS_ST_WRITE});
      cyc(CIBS_CYC_HALT);
      chk16({14'h0000, st_now[2:1]}, {14'h0000, CIBS_ST_HALT});
      $display("bus test done");
   endtask
   task automatic t_ready();
      int n0;
      cyc(CIBS_CYC_READ);
      n0 = lowc;
      wait_cyc = 4'h4;
      tick(3);
      cyc(CIBS_CYC_READ);
      chk1(1'(lowc >= n0 + 4), 1'b1);
      wait_cyc = 4'h0;
      $display("ready test done");
   endtask
   task automatic t_mask();
      rst55_in = 1'b1;
      tick(3);
      ei();
      samp(r);
      chk16(r & 16'h0100, 16'h0000);
      mset(3'b110, 1'b0);
      disable_irq_instruction = 1'b1;
      tick();
      disable_irq_instruction = 1'b0;
      samp(r);
      chk16(r & 16'h0100, 16'h0000);
      ei();
      samp(r);
      chk16(r, {8'h01, CIBS_VEC_R55});
      chk1(global_irq_enable, 1'b0);
      rst55_in = 1'b0;
      $display("mask test done");
   endtask
   task automatic t_r75();
      mset(3'b111, 1'b0);
      pulse75();
      mrd(d);
      chk1(d[CIBS_RD_P75], 1'b1);
      mset(3'b111, 1'b1);
      mrd(d);
      chk1(d[CIBS_RD_P75], 1'b0);
      pulse75();
      mset(3'b011, 1'b0);
      mrd(d);
      chk16({8'h00, d}, 16'h0043);
      ei();
      samp(r);
      chk16(r, {8'h01, CIBS_VEC_R75});
      mrd(d);
      chk1(d[CIBS_RD_P75], 1'b0);
      $display("edge test done");
   endtask
   task automatic t_prio();
      logic [7:0] ev[4] = '{CIBS_VEC_R75, CIBS_VEC_R65, CIBS_VEC_R55, CIBS_VEC_NONE};
      mset(3'b000, 1'b0);
      rst55_in = 1'b1;
      rst65_in = 1'b1;
      general_irq_input = 1'b1;
      pulse75();
      for (int i = 0; i < 4; i++) begin
         ei();
         samp(r);
         chk16(r, {8'h01, ev[i]});
         {rst65_in, rst55_in} = {i < 1, i < 2};
         tick(2);
      end
      chk16({13'h0000, irq_src}, {13'h0000, CIBS_SRC_GEN});
      rst55_in = 1'b0;
      rst65_in = 1'b0;
      general_irq_input = 1'b0;
      tick(3);
      cyc(CIBS_CYC_READ);
      chk16({14'h0000, saw_ack, saw_rd}, 16'h0002);
      cyc(CIBS_CYC_HALT);
      cyc(CIBS_CYC_READ);
      chk16({14'h0000, saw_ack, saw_rd}, 16'h0001);
      cyc(CIBS_CYC_ACK);
      chk16({14'h0000, saw_ack, saw_rd}, 16'h0002);
      $display("priority test done");
   endtask
   task automatic t_trap();
      mset(3'b111, 1'b0);
      trap_keep = 1'b1;
      trap_go = 1'b1;
      tick();
      trap_go = 1'b0;
      tick(3);
      samp(r);
      chk16(r, {8'h01, CIBS_VEC_TRAP});
      samp(r);
      chk16(r & 16'h0100, 16'h0000);
      trap_keep = 1'b0;
      tick(3);
      trap_go = 1'b1;
      tick();
      trap_go = 1'b0;
      tick(3);
      samp(r);
      chk16(r, {8'h01, CIBS_VEC_TRAP});
      $display("trap test done");
   endtask
   task automatic t_restart();
      logic [2:0] ix[2] = '{3'h0, 3'h7};
      for (int i = 0; i < 2; i++) begin
         rst_instr = 1'b1;
         rst_index = ix[i];
         tick();
         rst_instr = 1'b0;
         chk16(jump_addr, {10'h000, ix[i], 3'h0});
         chk16(sp_next, 16'h1ffe);
         chk16(push_addr, 16'h1234);
         tick();
      end
      $display("restart test done");
   endtask
   task automatic t_serial();
      serial_in_line = 1'b1;
      mrd(d);
      chk16({8'h00, d}, 16'h0087);
      mask_set_instruction = 1'b1;
      set_sod_upd = 1'b1;
      tick();
      mask_set_instruction = 1'b0;
      set_sod_upd = 1'b0;
      chk1(serial_out_line, 1'b0);
      mrd(d);
      chk16({13'h0000, d[2:0]}, 16'h0007);
      $display("serial test done");
   endtask
   // reset for 20 cycles, then every scenario in turn
   initial begin
      tick(20);
      rst_n = 1'b1;
      tick();
      t_reset();
      t_bus();
      t_ready();
      t_mask();
      t_r75();
      t_prio();
      t_trap();
      t_restart();
      t_serial();
      test_done();
   end
endmodule
`default_nettype wire
